//--- core/hfq_cfg.svh
// How it works
// - tx space event when empty count at/below threshold
// - tx space field counts empty transmit locations
// - live flag high while empty count at/below threshold
// - both reset bits together reset every register
// - status byte follows each frame's last byte
// - status byte: crc, abort, overrun, odd count
// - abort bit passed only as the engine reports
// - odd bit count flagged, no partial byte stored
// - last two bytes before end never stored
// - status byte write raises frame end event, overflow entry excepted
// - queue count includes status bytes
// - count stops at first status byte
// - no status byte: count is total, flag low
// - queue status read leaves fifos untouched
// - fill threshold crossing raises fill event
// - overflow overwrites last entry with status byte
// - overflow raises event, discards further data
// - overflow clears after status read and pop
// - check bytes never enter the receive fifo
`ifndef HFQ_CFG_SVH
`define HFQ_CFG_SVH
`define HFQ_FIFO_DEPTH 64
`define HFQ_ADR_TX_LVL 8'h00
`define HFQ_ADR_TX_SPACE 8'h04
`define HFQ_ADR_RX_QUEUE 8'h08
`define HFQ_ADR_RX_THR 8'h0c
`define HFQ_ADR_CTRL 8'h10
`define HFQ_ADR_IRQ_ST 8'h14
`define HFQ_ADR_IRQ_EN 8'h18
`define HFQ_ADR_TX_DATA 8'h1c
`define HFQ_ADR_RX_DATA 8'h20
`define HFQ_CTRL_TX_RST 5
`define HFQ_CTRL_RX_RST 4
`define HFQ_IRQ_OVR 5
`define HFQ_IRQ_REND 4
`define HFQ_IRQ_FILL 3
`define HFQ_IRQ_TXSP 1
`define HFQ_SF_BAD_CRC 7
`define HFQ_SF_ABORT 6
`define HFQ_SF_ODD 4
`define HFQ_SF_OVR_BYTE 8'h20
`define HFQ_LVL_RESET 6'h00
`define HFQ_THR_RESET 6'h00
`define HFQ_HOLD_BYTES 2
`endif

//--- core/hfq_pkg.sv
package hfq_pkg;
  // end-of-frame report from the receive engine
  typedef struct packed {
    logic bad_crc;
    logic abort;
    logic odd_bits;
  } hfq_rx_end_t;
  // event bits, used for status and enables
  typedef struct packed {
    logic ovr;
    logic rend;
    logic fill;
    logic txsp;
  } hfq_irq_t;
endpackage

//--- core/hfq_byte_fifo.sv
`timescale 1ns/1ps
module hfq_byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 64
) (
  // clock and clear
  input wire logic clk_i,
  input wire logic clear_i,
  // write side
  input wire logic push_i,
  input wire logic [W-1:0] data_i,
  // read side
  input wire logic pop_i,
  output logic [W-1:0] head_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;

  ////////////////////////////////////////////////////////////////////////////
  // pointer and count update; caller never overfills or overdrains
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (clear_i) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end else begin
      if (push_i) begin
        wr_d = wr_q + 1'b1;
      end
      if (pop_i) begin
        rd_d = rd_q + 1'b1;
      end
      cnt_d = cnt_q + CW'(push_i) - CW'(pop_i);
    end
  end

  // registers and storage
  always_ff @(posedge clk_i) begin
    wr_q <= wr_d;
    rd_q <= rd_d;
    cnt_q <= cnt_d;
    if (push_i && !clear_i) begin
      mem[wr_q] <= data_i;
    end
  end

  assign head_o = mem[rd_q];
  assign count_o = cnt_q;
endmodule // hfq_byte_fifo

//--- core/hfq_queue_status.sv
`timescale 1ns/1ps
`include "hfq_cfg.svh"
module hfq_queue_status import hfq_pkg::*; #(
  parameter int DEPTH = `HFQ_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // transmit engine side
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_take_i,
  // receive engine side
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_end_i,
  input wire hfq_rx_end_t rx_end_flags_i,
  // event output
  output logic irq_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic req, acc_wr, acc_rd, ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [7:0] adr_w;
  logic wr_ctrl, chip_rst, reg_rst, tx_clr, rx_clr, st_rd, tx_push, rx_pop;
  logic pop_ok_q, pop_ok_d;
  assign req = wb_cyc_i & wb_stb_i;
  assign adr_w = {wb_adr_i[7:2], 2'b00};
  assign acc_wr = req & ack_q & wb_we_i & wb_sel_i[0];
  assign acc_rd = req & ack_q & ~wb_we_i;
  assign wr_ctrl = acc_wr && (adr_w == `HFQ_ADR_CTRL);
  assign chip_rst = wr_ctrl & wb_dat_i[`HFQ_CTRL_TX_RST] & wb_dat_i[`HFQ_CTRL_RX_RST];
  assign reg_rst = rst_i | chip_rst;
  assign tx_clr = rst_i | (wr_ctrl & wb_dat_i[`HFQ_CTRL_TX_RST]);
  assign rx_clr = rst_i | (wr_ctrl & wb_dat_i[`HFQ_CTRL_RX_RST]);
  assign st_rd = acc_rd && (adr_w == `HFQ_ADR_IRQ_ST);

  ////////////////////////////////////////////////////////////////////////////
  // transmit queue and output stage
  logic [CW-1:0] tx_cnt, space;
  logic [7:0] tx_head, txd_q, txd_d;
  logic txv_q, txv_d, tx_pop, tx_live;
  logic [5:0] lvl_q, lvl_d, thr_q, thr_d;

  hfq_byte_fifo #(
    .W(8),
    .DEPTH(DEPTH)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .clear_i(tx_clr),
    .push_i(tx_push),
    .data_i(wb_dat_i[7:0]),
    .pop_i(tx_pop),
    .head_o(tx_head),
    .count_o(tx_cnt)
  );

  // empty locations include the output stage
  assign space = CW'(DEPTH) - tx_cnt - CW'(txv_q);
  assign tx_live = space <= CW'(lvl_q);
  assign tx_push = acc_wr && (adr_w == `HFQ_ADR_TX_DATA) && (space != '0);
  assign tx_pop = (tx_cnt != '0) && (!txv_q || tx_take_i) && !tx_clr;

  // output stage next state
  always_comb begin
    txv_d = txv_q;
    txd_d = txd_q;
    if (tx_clr) begin
      txv_d = 1'b0;
      txd_d = 8'h00;
    end else if (tx_pop) begin
      txv_d = 1'b1;
      txd_d = tx_head;
    end else if (tx_take_i) begin
      txv_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive queue with hold-back and status tags
  logic [7:0] mem [DEPTH];
  logic [DEPTH-1:0] tag_q, tag_d;
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d, m_wa;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [1:0][7:0] h_q, h_d;
  logic [1:0] hcnt_q, hcnt_d;
  logic ovr_q, ovr_d, sst_q, sst_d, srd_q, srd_d;
  logic m_we, push, p_tag, ovw, sf_push;
  logic [7:0] m_wd, p_byte, sf;

  assign rx_pop = acc_rd && (adr_w == `HFQ_ADR_RX_DATA) && pop_ok_q; // only a byte handed out

  // status byte from the engine's report
  always_comb begin
    sf = 8'h00;
    sf[`HFQ_SF_BAD_CRC] = rx_end_flags_i.bad_crc;
    sf[`HFQ_SF_ABORT] = rx_end_flags_i.abort;
    sf[`HFQ_SF_ODD] = rx_end_flags_i.odd_bits;
  end

  // queue next state
  always_comb begin
    h_d = h_q;
    hcnt_d = hcnt_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    tag_d = tag_q;
    ovr_d = ovr_q;
    sst_d = sst_q;
    srd_d = srd_q;
    m_we = 1'b0;
    m_wa = wr_q;
    m_wd = 8'h00;
    push = 1'b0;
    p_byte = 8'h00;
    p_tag = 1'b0;
    ovw = 1'b0;
    sf_push = 1'b0;
    if (rx_pop) begin
      tag_d[rd_q] = 1'b0;
      rd_d = rd_q + 1'b1;
      cnt_d = cnt_q - 1'b1;
    end
    if (rx_end_i && !ovr_q) begin
      push = 1'b1;
      p_byte = sf;
      p_tag = 1'b1;
      hcnt_d = 2'd0;
    end else if (rx_byte_valid_i && !ovr_q) begin
      h_d[0] = rx_byte_i;
      h_d[1] = h_q[0];
      if (hcnt_q == 2'(`HFQ_HOLD_BYTES)) begin
        push = 1'b1;
        p_byte = h_q[1];
      end else begin
        hcnt_d = hcnt_q + 2'd1;
      end
    end
    if (push) begin
      m_we = 1'b1;
      if ((cnt_q == CW'(DEPTH)) && !rx_pop) begin
        ovw = 1'b1;
        m_wa = wr_q - 1'b1;
        m_wd = `HFQ_SF_OVR_BYTE;
        tag_d[m_wa] = 1'b1;
        ovr_d = 1'b1;
        sst_d = 1'b0;
        srd_d = 1'b0;
        hcnt_d = 2'd0;
      end else begin
        m_wd = p_byte;
        tag_d[wr_q] = p_tag;
        wr_d = wr_q + 1'b1;
        cnt_d = cnt_d + 1'b1;
        sf_push = p_tag;
      end
    end
    if (ovr_q) begin
      sst_d = sst_q | st_rd;
      srd_d = srd_q | rx_pop;
      if ((sst_q | st_rd) && (srd_q | rx_pop)) begin
        ovr_d = 1'b0;
        sst_d = 1'b0;
        srd_d = 1'b0;
      end
    end
    if (rx_clr) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
      tag_d = '0;
      hcnt_d = 2'd0;
      ovr_d = 1'b0;
      sst_d = 1'b0;
      srd_d = 1'b0;
      m_we = 1'b0;
      sf_push = 1'b0;
      ovw = 1'b0;
    end
  end

  // distance to the first status byte; the flag freezes the count
  logic [CW-1:0] rx_queue_count;
  logic eof;
  always_comb begin
    logic [AW-1:0] idx;
    logic found;
    idx = rd_q;
    found = 1'b0;
    rx_queue_count = cnt_q;
    for (int i = 0; i < DEPTH; i++) begin
      idx = rd_q + AW'(i);
      if (!found && (i < int'(cnt_q)) && tag_q[idx]) begin
        found = 1'b1;
        rx_queue_count = CW'(i + 1);
      end
    end
    eof = found;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers and events
  hfq_irq_t en_q, en_d, st_q, st_d, set;
  logic irq_q, irq_d, fill_set;
  logic [7:0] ist_rd, ien_rd;

  assign fill_set = (thr_q != 6'h00) && (cnt_d >= CW'(thr_q)) && (cnt_q < CW'(thr_q));

  // register image of status and enables
  always_comb begin
    ist_rd = 8'h00;
    ien_rd = 8'h00;
    ist_rd[`HFQ_IRQ_OVR] = st_q.ovr;
    ist_rd[`HFQ_IRQ_REND] = st_q.rend;
    ist_rd[`HFQ_IRQ_FILL] = st_q.fill;
    ist_rd[`HFQ_IRQ_TXSP] = st_q.txsp;
    ien_rd[`HFQ_IRQ_OVR] = en_q.ovr;
    ien_rd[`HFQ_IRQ_REND] = en_q.rend;
    ien_rd[`HFQ_IRQ_FILL] = en_q.fill;
    ien_rd[`HFQ_IRQ_TXSP] = en_q.txsp;
  end

  // settings, sticky status (set beats read-clear) and event pin
  always_comb begin
    lvl_d = lvl_q;
    thr_d = thr_q;
    en_d = en_q;
    set.ovr = ovw;
    set.rend = sf_push;
    set.fill = fill_set & ~rx_clr;
    set.txsp = tx_live;
    st_d = hfq_irq_t'((st_rd ? 4'h0 : st_q) | set);
    if (acc_wr) begin
      case (adr_w)
        `HFQ_ADR_TX_LVL: lvl_d = wb_dat_i[5:0];
        `HFQ_ADR_RX_THR: thr_d = wb_dat_i[5:0];
        `HFQ_ADR_IRQ_EN: begin
          en_d.ovr = wb_dat_i[`HFQ_IRQ_OVR];
          en_d.rend = wb_dat_i[`HFQ_IRQ_REND];
          en_d.fill = wb_dat_i[`HFQ_IRQ_FILL];
          en_d.txsp = wb_dat_i[`HFQ_IRQ_TXSP];
        end
        default: ;
      endcase
    end
    if (reg_rst) begin
      lvl_d = `HFQ_LVL_RESET;
      thr_d = `HFQ_THR_RESET;
      en_d = '0;
      st_d = '0;
    end
    irq_d = |(st_q & en_q) & ~reg_rst;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait state, data sampled as ack rises
  always_comb begin
    ack_d = req & ~ack_q & ~rst_i;
    pop_ok_d = req & ~ack_q & ~rst_i & (adr_w == `HFQ_ADR_RX_DATA) & (cnt_q != '0);
    dat_d = dat_q;
    if (rst_i) begin
      dat_d = 32'h0000_0000;
    end else if (req & ~ack_q) begin
      case (adr_w)
        `HFQ_ADR_TX_LVL: dat_d = 32'({2'b00, lvl_q});
        `HFQ_ADR_TX_SPACE: dat_d = 32'({tx_live, space});
        `HFQ_ADR_RX_QUEUE: dat_d = 32'({eof, rx_queue_count});
        `HFQ_ADR_RX_THR: dat_d = 32'({2'b00, thr_q});
        `HFQ_ADR_IRQ_ST: dat_d = 32'(ist_rd);
        `HFQ_ADR_IRQ_EN: dat_d = 32'(ien_rd);
        `HFQ_ADR_RX_DATA: dat_d = (cnt_q != '0) ? 32'(mem[rd_q]) : 32'h0000_0000;
        default: dat_d = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // all state registers
  always_ff @(posedge clk_i) begin
    ack_q <= ack_d;
    dat_q <= dat_d;
    pop_ok_q <= pop_ok_d;
    txv_q <= txv_d;
    txd_q <= txd_d;
    lvl_q <= lvl_d;
    thr_q <= thr_d;
    en_q <= en_d;
    st_q <= st_d;
    irq_q <= irq_d;
    h_q <= h_d;
    hcnt_q <= hcnt_d;
    wr_q <= wr_d;
    rd_q <= rd_d;
    cnt_q <= cnt_d;
    tag_q <= tag_d;
    ovr_q <= ovr_d;
    sst_q <= sst_d;
    srd_q <= srd_d;
    if (m_we) begin
      mem[m_wa] <= m_wd;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign tx_valid_o = txv_q;
  assign tx_data_o = txd_q;
  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_tx_space_event: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_live && !chip_rst |=> st_q.txsp) else $error("tx space event missed");
  a_tx_space_count: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_push && !tx_pop && !tx_clr && !txv_q |=> space == $past(space) - 1'b1)
    else $error("tx space count wrong");
  a_chip_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    chip_rst |=> lvl_q == 6'h00 && thr_q == 6'h00 && en_q == '0 && space == CW'(DEPTH))
    else $error("chip reset incomplete");
  a_crc_holdback: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_end_i && !ovr_q && !rx_clr && !rx_pop && cnt_q < CW'(DEPTH)
    |=> cnt_q == $past(cnt_q) + 1'b1 && st_q.rend) else $error("end did not add one byte");
  a_no_sf_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (tag_q == '0) |-> !eof && rx_queue_count == cnt_q) else $error("count without status wrong");
  a_status_read_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_rd && adr_w == `HFQ_ADR_RX_QUEUE && !rx_clr |=> rd_q == $past(rd_q))
    else $error("status read moved fifo");
  a_overrun_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    ovw |=> ovr_q && st_q.ovr && mem[wr_q - 1'b1] == `HFQ_SF_OVR_BYTE)
    else $error("overrun entry wrong");
  a_overrun_discard: assert property (@(posedge clk_i) disable iff (rst_i)
    ovr_q && !rx_clr |=> cnt_q <= $past(cnt_q)) else $error("data stored in overrun");
  a_overrun_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(ovr_q) && !$past(rx_clr) |-> $past(sst_q | st_rd) && $past(srd_q | rx_pop))
    else $error("overrun cleared early");
  a_rx_reset_empty: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_clr |=> cnt_q == '0 && !eof && !ovr_q) else $error("rx reset left data");
  a_irq_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(st_q & en_q)) && !reg_rst |=> irq_o) else $error("event pin not raised");
endmodule // hfq_queue_status

//--- testbench/hfq_engine_model.sv
`timescale 1ns/1ps
module hfq_engine_model import hfq_pkg::*; (
  // clock
  input wire logic clk_i,
  // transmit engine
  input wire logic tx_valid_i,
  input wire logic take_en_i,
  output logic tx_take_o,
  // receive engine
  output logic rx_byte_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_end_o,
  output hfq_rx_end_t rx_end_flags_o
);
  // take the head byte only while the bench allows it, to stall the queue
  assign tx_take_o = tx_valid_i & take_en_i;
  // idle receive lines
  initial begin
    rx_byte_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_end_o = 1'b0;
    rx_end_flags_o = 3'h0;
  end
  // n destuffed bytes 1..n back to back; the last two are the check bytes
  task automatic send(input int n, input hfq_rx_end_t f);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      rx_byte_valid_o <= 1'b1;
      rx_byte_o <= 8'(k + 1);
    end
    // closing event; abort only when the frame engine saw one
    @(posedge clk_i);
    rx_byte_valid_o <= 1'b0;
    rx_byte_o <= ~rx_byte_o;
    rx_end_o <= 1'b1;
    rx_end_flags_o <= f;
    @(posedge clk_i);
    rx_end_o <= 1'b0;
    rx_end_flags_o <= ~f;
  endtask
endmodule // hfq_engine_model

//--- testbench/hfq_queue_status_test.sv
`timescale 1ns/1ps
module hfq_queue_status_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic take_en = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, tx_valid, tx_take, rx_vld, rx_end, irq;
  logic [7:0] tx_data, rx_byte;
  hfq_pkg::hfq_rx_end_t rx_flags;
  int error_cnt = 0;
  int checks_done = 0;

  ////////////////////////////////////////////////////////////////////////
  // design and engine model
  hfq_queue_status #(.DEPTH(64)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_take_i(tx_take),
    .rx_byte_valid_i(rx_vld), .rx_byte_i(rx_byte), .rx_end_i(rx_end),
    .rx_end_flags_i(rx_flags), .irq_o(irq));
  hfq_engine_model i_eng (
    .clk_i(clk_i), .tx_valid_i(tx_valid), .take_en_i(take_en), .tx_take_o(tx_take),
    .rx_byte_valid_o(rx_vld), .rx_byte_o(rx_byte), .rx_end_o(rx_end),
    .rx_end_flags_o(rx_flags));
  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // verdict
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle, ack awaited under a bound
  task automatic wb(input logic w, input logic [7:0] a, d, output logic [7:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h00_0000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      results();
    end
  endtask
  // register write and checked read
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, e);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    wr(8'h3c, 8'h5a);
    rc(8'h3c, 8'h00);
    rc(8'h00, 8'h00);
    rc(8'h04, 8'h40);
    rc(8'h20, 8'h00);
    rc(8'h08, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_tx();
    int n;
    wr(8'h00, 8'h3f);
    wr(8'h18, 8'h02);
    wr(8'h1c, 8'ha5);
    rc(8'h04, 8'hbf);
    chk({7'h00, irq}, 8'h01);
    rc(8'h14, 8'h02);
    chk({7'h00, tx_valid}, 8'h01);
    chk(tx_data, 8'ha5);
    take_en <= 1'b1;
    for (n = 0; n < 20 && tx_valid !== 1'b0; n++) @(posedge clk_i);
    take_en <= 1'b0;
    chk(8'(n == 20), 8'h00);
    if (n == 20) begin
      results();
    end
    rc(8'h04, 8'h40);
    rc(8'h14, 8'h02);
    rc(8'h14, 8'h00);
    $display("tx space done");
  endtask
  task automatic t_rx();
    wr(8'h0c, 8'h03);
    wr(8'h18, 8'h18);
    i_eng.send(4, 3'b100);
    repeat (3) @(posedge clk_i);
    chk({7'h00, irq}, 8'h01);
    // mask the fill event while the frame is serviced
    wr(8'h18, 8'h10);
    rc(8'h08, 8'h83);
    rc(8'h08, 8'h83);
    rc(8'h14, 8'h18);
    rc(8'h20, 8'h01);
    rc(8'h08, 8'h82);
    rc(8'h20, 8'h02);
    rc(8'h08, 8'h81);
    rc(8'h20, 8'h80);
    rc(8'h08, 8'h00);
    // closing status read finds no event pending, then unmask
    rc(8'h14, 8'h00);
    wr(8'h18, 8'h18);
    $display("rx frame done");
  endtask
  // transmit-only and combined resets, host never sets both except on purpose
  task automatic t_resets();
    wr(8'h00, 8'h05);
    wr(8'h1c, 8'h11);
    wr(8'h10, 8'h20);
    rc(8'h04, 8'h40);
    rc(8'h00, 8'h05);
    wr(8'h1c, 8'h22);
    wr(8'h10, 8'h30);
    rc(8'h00, 8'h00);
    rc(8'h0c, 8'h00);
    rc(8'h18, 8'h00);
    rc(8'h10, 8'h00);
    rc(8'h04, 8'h40);
    $display("resets done");
  endtask
  task automatic t_overrun();
    wr(8'h18, 8'h20);
    i_eng.send(68, 3'b000);
    repeat (3) @(posedge clk_i);
    chk({7'h00, irq}, 8'h01);
    rc(8'h08, 8'hc0);
    rc(8'h14, 8'h20);
    for (int i = 1; i < 64; i++) rc(8'h20, 8'(i));
    rc(8'h20, 8'h20);
    rc(8'h08, 8'h00);
    i_eng.send(2, 3'b011);
    repeat (3) @(posedge clk_i);
    rc(8'h08, 8'h81);
    rc(8'h20, 8'h50);
    $display("overrun done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_resets();
    t_overrun();
    results();
  end
endmodule // hfq_queue_status_test
